// *** verilog/sdra_pkg.sv ***
// How it works
// R01: All link inputs captured on rising clock.
// R02: Four banks, 2048 rows, 256 columns, 32 bits.
// R03: Activate: bank selects pick bank, address picks row.
// R04: Column command: low eight address bits start column.
// R05: Controller opens a row before column commands.
// R06: Bursts of 1, 2, 4, 8 or page.
// R07: Burst terminate ends a running burst early.
// R08: Auto precharge closes the row after burst.
// R09: New column command accepted every clock.
// R10: Precharge one bank while another is accessed.
// R11: Auto precharge runs alongside other-bank commands.
// R12: Read latency selectable as 1, 2 or 3.
// R13: Controller issues 4096 refreshes per 64 ms.
// R14: Power-down mode entered and left by controller.
// R15: Read burst drives one word per clock.
package sdra_pkg;
	localparam int ROW_W  = 11;
	localparam int COL_W  = 8;
	localparam int BANK_W = 2;
	localparam int NBANK  = 4;
	localparam int DATA_W = 32;

	// Command codes as {cs_n, ras_n, cas_n, we_n}.
	localparam logic [3:0] CMD_LMR = 4'h0;
	localparam logic [3:0] CMD_REF = 4'h1;
	localparam logic [3:0] CMD_PRE = 4'h2;
	localparam logic [3:0] CMD_ACT = 4'h3;
	localparam logic [3:0] CMD_WR  = 4'h4;
	localparam logic [3:0] CMD_RD  = 4'h5;
	localparam logic [3:0] CMD_BST = 4'h6;
	localparam logic [3:0] CMD_NOP = 4'h7;

	// Address bit 10 asks for auto precharge, or all banks on a precharge.
	localparam int AP_BIT = 10;

	// Mode word carried on the address bus by a mode load.
	localparam int         MODE_W      = 6;
	localparam int         MODE_BL_LSB = 0;
	localparam int         MODE_BT_BIT = 3;
	localparam int         MODE_LAT_LSB = 4;
	localparam logic [2:0] BL_PAGE     = 3'h7;
	localparam logic [2:0] BL_MAX_POW  = 3'h3;
	localparam logic [5:0] MODE_RESET  = 6'h10;

	// Refresh timing.
	localparam int  REF_WINDOW_MS = 64;
	localparam int  REF_ROWS      = 4096;
	localparam real REF_AVG_US    = 15.6;
	localparam real CLK_MHZ       = 250.0;
	localparam int  REF_CYCLES    = int'($floor(REF_AVG_US * CLK_MHZ));

	// Controller register map (byte offsets).
	localparam logic [7:0] REG_CMD    = 8'h00;
	localparam logic [7:0] REG_ADDR   = 8'h04;
	localparam logic [7:0] REG_WDATA  = 8'h08;
	localparam logic [7:0] REG_RDATA  = 8'h0c;
	localparam logic [7:0] REG_MODE   = 8'h10;
	localparam logic [7:0] REG_CTRL   = 8'h14;
	localparam logic [7:0] REG_STATUS = 8'h18;

	localparam int          ADDR_COL_LSB  = 0;
	localparam int          ADDR_ROW_LSB  = 8;
	localparam int          ADDR_BANK_LSB = 19;
	localparam int          ST_BUSY_BIT   = 0;
	localparam int          ST_PD_BIT     = 1;
	localparam int          ST_REF_BIT    = 2;
	localparam logic [31:0] CTRL_RESET    = 32'h0000_0001;

	localparam logic [2:0] OP_READ     = 3'h1;
	localparam logic [2:0] OP_WRITE    = 3'h2;
	localparam logic [2:0] OP_MODE     = 3'h3;
	localparam logic [2:0] OP_PD_ENTER = 3'h4;
	localparam logic [2:0] OP_PD_EXIT  = 3'h5;
	localparam logic [2:0] OP_PRE_ALL  = 3'h6;

	typedef enum logic [1:0] {
		HS_IDLE = 2'b00,
		HS_ACT  = 2'b01,
		HS_CMD  = 2'b11,
		HS_WAIT = 2'b10
	} sdra_hstate_e;
endpackage : sdra_pkg

// *** verilog/sdra_link.sv ***
`timescale 1ns/10ps
interface sdra_link
	import sdra_pkg::*;
	#(parameter int AW = ROW_W, parameter int DW = DATA_W) ();
	logic          cke;
	logic          cs_n;
	logic          ras_n;
	logic          cas_n;
	logic          we_n;
	logic          bank_select_low;
	logic          bank_select_high;
	logic [AW-1:0] addr;
	logic [DW-1:0] ctl_dq;
	logic          ctl_dq_oe_n;
	logic [DW-1:0] mem_dq;
	logic          mem_dq_oe_n;
	logic [DW-1:0] dq;

	// Shared data wire level, worked out from the two enables.
	assign dq = !ctl_dq_oe_n ? ctl_dq : (!mem_dq_oe_n ? mem_dq : '0);

	modport ctl (output cke, cs_n, ras_n, cas_n, we_n, bank_select_low, bank_select_high,
		addr, ctl_dq, ctl_dq_oe_n, input dq);
	modport mem (input cke, cs_n, ras_n, cas_n, we_n, bank_select_low, bank_select_high,
		addr, dq, output mem_dq, mem_dq_oe_n);
endinterface : sdra_link

// *** verilog/sdra_refresh_timer.sv ***
`timescale 1ns/10ps
module sdra_refresh_timer
	import sdra_pkg::*;
	#(parameter int CYCLES = REF_CYCLES) (
	input  wire logic sys_clk,
	input  wire logic rst,
	input  wire logic enable,
	output logic      tick
);
	if (CYCLES < 2) begin : g_bad
		$error("Refresh interval too short.");
	end

	logic [$clog2(CYCLES)-1:0] cnt_r;
	logic [$clog2(CYCLES)-1:0] cnt_nxt;
	logic                      tick_r;
	logic                      tick_nxt;

	always_comb begin
		cnt_nxt  = cnt_r;
		tick_nxt = 1'b0;
		if (!enable) begin
			cnt_nxt = '0;
		end else if (cnt_r == ($clog2(CYCLES))'(CYCLES - 1)) begin
			cnt_nxt  = '0;
			tick_nxt = 1'b1;
		end else begin
			cnt_nxt = cnt_r + 1'b1;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cnt_r  <= '0;
			tick_r <= 1'b0;
		end else begin
			cnt_r  <= cnt_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign tick = tick_r;
endmodule : sdra_refresh_timer

// *** verilog/sdra_host.sv ***
`timescale 1ns/10ps
module sdra_host
	import sdra_pkg::*;
	#(parameter int REF_INTERVAL = REF_CYCLES) (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	sdra_link.ctl            lnk
);
	logic         wr_pend_r, wr_pend_nxt;
	logic [7:0]   wr_off_r, wr_off_nxt;
	logic [31:0]  hrdata_r, hrdata_nxt;
	sdra_hstate_e st_r, st_nxt;
	logic [31:0]  addr_r, addr_nxt, wdata_r, wdata_nxt, rdata_r, rdata_nxt, ctrl_r, ctrl_nxt;
	logic [5:0]   mode_r, mode_nxt;
	logic [2:0]   op_r, op_nxt;
	logic [1:0]   wait_r, wait_nxt;
	logic         ref_pend_r, ref_pend_nxt, cke_r, cke_nxt, oe_n_r, oe_n_nxt;
	logic [3:0]   cmd_r, cmd_nxt;
	logic [1:0]   bank_r, bank_nxt;
	logic [10:0]  la_r, la_nxt;
	logic [31:0]  dq_r, dq_nxt;
	logic         tick, take;
	logic [31:0]  status;

	sdra_refresh_timer #(.CYCLES(REF_INTERVAL)) u_ref (
		.sys_clk (sys_clk),
		.rst     (rst),
		.enable  (ctrl_r[0]),
		.tick    (tick)
	);

	// An accepted order counts as busy before the sequencer leaves idle.
	assign status = {29'h0, ref_pend_r, !cke_r, (st_r != HS_IDLE) || (op_r != 3'h0)};
	assign take   = hsel && htrans[1] && hready;

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		wr_pend_nxt = take && hwrite;
		wr_off_nxt  = take ? haddr[7:0] : wr_off_r;
		hrdata_nxt  = hrdata_r;
		if (take && !hwrite) begin
			case (haddr[7:0])
				REG_ADDR:   hrdata_nxt = addr_r;
				REG_WDATA:  hrdata_nxt = wdata_r;
				REG_RDATA:  hrdata_nxt = rdata_r;
				REG_MODE:   hrdata_nxt = {26'h0, mode_r};
				REG_CTRL:   hrdata_nxt = ctrl_r;
				REG_STATUS: hrdata_nxt = status;
				default:    hrdata_nxt = 32'h0;
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wr_pend_r <= 1'b0;
			wr_off_r  <= 8'h00;
			hrdata_r  <= 32'h0;
		end else begin
			wr_pend_r <= wr_pend_nxt;
			wr_off_r  <= wr_off_nxt;
			hrdata_r  <= hrdata_nxt;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_r;

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		st_nxt     = st_r;
		addr_nxt   = addr_r;
		wdata_nxt  = wdata_r;
		rdata_nxt  = rdata_r;
		ctrl_nxt   = ctrl_r;
		mode_nxt   = mode_r;
		op_nxt     = op_r;
		wait_nxt   = wait_r;
		cke_nxt    = cke_r;
		cmd_nxt    = CMD_NOP;
		bank_nxt   = bank_r;
		la_nxt     = la_r;
		dq_nxt     = dq_r;
		oe_n_nxt   = 1'b1;
		// R13: refresh due
		ref_pend_nxt = ref_pend_r || tick;
		if (wr_pend_r) begin
			case (wr_off_r)
				REG_CMD:   op_nxt    = (st_r == HS_IDLE) ? hwdata[2:0] : op_r;
				REG_ADDR:  addr_nxt  = hwdata;
				REG_WDATA: wdata_nxt = hwdata;
				REG_MODE:  mode_nxt  = hwdata[5:0];
				REG_CTRL:  ctrl_nxt  = hwdata;
				default:   ;
			endcase
		end
		case (st_r)
			HS_IDLE: begin
				if (ref_pend_r && cke_r) begin
					cmd_nxt      = CMD_REF;
					ref_pend_nxt = tick;
				end else begin
					// A freshly written order must survive until it is served.
					if (op_r != 3'h0)
						op_nxt = 3'h0;
					case (op_r)
						// R05: open the row first
						OP_READ, OP_WRITE: begin
							op_nxt   = op_r;
							cmd_nxt  = CMD_ACT;
							bank_nxt = addr_r[ADDR_BANK_LSB +: BANK_W];
							la_nxt   = addr_r[ADDR_ROW_LSB +: ROW_W];
							st_nxt   = cke_r ? HS_ACT : HS_IDLE;
							cmd_nxt  = cke_r ? CMD_ACT : CMD_NOP;
						end
						OP_MODE: begin
							cmd_nxt = CMD_LMR;
							la_nxt  = {5'h0, mode_r};
						end
						// R14: power-down entry and exit
						OP_PD_ENTER: cke_nxt = 1'b0;
						OP_PD_EXIT:  cke_nxt = 1'b1;
						OP_PRE_ALL: begin
							cmd_nxt = CMD_PRE;
							la_nxt  = 11'h400;
						end
						default: ;
					endcase
				end
			end
			HS_ACT: begin
				cmd_nxt = (op_r == OP_WRITE) ? CMD_WR : CMD_RD;
				la_nxt  = {3'h4, addr_r[ADDR_COL_LSB +: COL_W]};
				dq_nxt  = wdata_r;
				oe_n_nxt = (op_r != OP_WRITE);
				st_nxt  = HS_CMD;
			end
			HS_CMD: begin
				// Count one short of the latency so the word is taken while it stands.
				wait_nxt = (mode_r[MODE_LAT_LSB +: 2] == 2'h0) ? 2'h0 :
					mode_r[MODE_LAT_LSB +: 2] - 2'h1;
				st_nxt   = (op_r == OP_WRITE) ? HS_IDLE : HS_WAIT;
				op_nxt   = (op_r == OP_WRITE) ? 3'h0 : op_r;
			end
			HS_WAIT: begin
				wait_nxt = wait_r - 2'h1;
				if (wait_r == 2'h0) begin
					rdata_nxt = lnk.dq;
					op_nxt    = 3'h0;
					st_nxt    = HS_IDLE;
				end
			end
			default: st_nxt = HS_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_r <= HS_IDLE;
			addr_r <= 32'h0;
			wdata_r <= 32'h0;
			rdata_r <= 32'h0;
			ctrl_r <= CTRL_RESET;
			mode_r <= MODE_RESET;
			op_r <= 3'h0;
			wait_r <= 2'h0;
			ref_pend_r <= 1'b0;
			cke_r <= 1'b1;
			cmd_r <= CMD_NOP;
			bank_r <= 2'h0;
			la_r <= 11'h0;
			dq_r <= 32'h0;
			oe_n_r <= 1'b1;
		end else begin
			st_r <= st_nxt;
			addr_r <= addr_nxt;
			wdata_r <= wdata_nxt;
			rdata_r <= rdata_nxt;
			ctrl_r <= ctrl_nxt;
			mode_r <= mode_nxt;
			op_r <= op_nxt;
			wait_r <= wait_nxt;
			ref_pend_r <= ref_pend_nxt;
			cke_r <= cke_nxt;
			cmd_r <= cmd_nxt;
			bank_r <= bank_nxt;
			la_r <= la_nxt;
			dq_r <= dq_nxt;
			oe_n_r <= oe_n_nxt;
		end
	end

	// R01: link outputs straight from flops
	assign {lnk.cs_n, lnk.ras_n, lnk.cas_n, lnk.we_n} = cmd_r;
	assign lnk.cke              = cke_r;
	assign lnk.bank_select_low  = bank_r[0];
	assign lnk.bank_select_high = bank_r[1];
	assign lnk.addr             = la_r;
	assign lnk.ctl_dq           = dq_r;
	assign lnk.ctl_dq_oe_n      = oe_n_r;
endmodule : sdra_host

// *** verilog/sdra_device.sv ***
`timescale 1ns/10ps
module sdra_device
	import sdra_pkg::*;
	#(parameter int RW = ROW_W, parameter int CW = COL_W) (
	input  wire logic sys_clk,
	input  wire logic rst,
	sdra_link.mem     lnk
);
	if (RW <= AP_BIT || CW > RW || CW < 3 || RW < MODE_W) begin : g_bad
		$error("Row or column width not supported.");
	end

	localparam int DEPTH = NBANK << (RW + CW);

	////////////////////////////////////////////////////////////////////////////////
	// R02: one array holding all four banks
	logic [DATA_W-1:0] mem [DEPTH];

	logic [NBANK-1:0]  open_r, open_nxt;
	logic [RW-1:0]     row_r [NBANK];
	logic [RW-1:0]     row_nxt [NBANK];
	logic [MODE_W-1:0] mode_r, mode_nxt;
	logic              bon_r, bon_nxt, bwr_r, bwr_nxt, bap_r, bap_nxt, bfull_r, bfull_nxt;
	logic [1:0]        bbank_r, bbank_nxt;
	logic [CW-1:0]     bstart_r, bstart_nxt, bk_r, bk_nxt, bleft_r, bleft_nxt;
	logic              acc, acc_wr;
	logic [1:0]        acc_bank;
	logic [CW-1:0]     acc_col;
	logic [RW+CW+1:0]  acc_idx;
	logic [3:0]        cmd;
	logic [1:0]        bank;
	logic [CW:0]       len;
	logic [2:0]        pv_r;
	logic [DATA_W-1:0] pd_r [3];
	logic [1:0]        lsel;

	// Column of step k, in sequential or interleaved order inside the burst.
	function automatic logic [CW-1:0] step_col(input logic [CW-1:0] start,
		input logic [CW-1:0] k, input logic [MODE_W-1:0] m);
		logic [CW-1:0] mask;
		mask = (m[MODE_BL_LSB +: 3] == BL_PAGE) ? '1 :
			CW'((1 << m[MODE_BL_LSB +: 2]) - 1);
		if (m[MODE_BT_BIT] && m[MODE_BL_LSB +: 3] != BL_PAGE)
			step_col = (start & ~mask) | ((start ^ k) & mask);
		else
			step_col = (start & ~mask) | ((start + k) & mask);
	endfunction : step_col

	assign cmd  = {lnk.cs_n, lnk.ras_n, lnk.cas_n, lnk.we_n};
	assign bank = {lnk.bank_select_high, lnk.bank_select_low};

	always_comb begin
		open_nxt   = open_r;
		row_nxt    = row_r;
		mode_nxt   = mode_r;
		bon_nxt    = bon_r;
		bwr_nxt    = bwr_r;
		bap_nxt    = bap_r;
		bfull_nxt  = bfull_r;
		bbank_nxt  = bbank_r;
		bstart_nxt = bstart_r;
		bk_nxt     = bk_r;
		bleft_nxt  = bleft_r;
		acc        = 1'b0;
		acc_wr     = bwr_r;
		acc_bank   = bbank_r;
		acc_col    = step_col(bstart_r, bk_r, mode_r);
		// R06: burst length from the mode word
		len = (mode_r[MODE_BL_LSB +: 3] == BL_PAGE) ? (CW+1)'(1 << CW) :
			(mode_r[MODE_BL_LSB +: 3] > BL_MAX_POW) ? (CW+1)'(1) :
			(CW+1)'(1 << mode_r[MODE_BL_LSB +: 2]);
		// R14: nothing moves while the clock enable is low
		if (lnk.cke) begin
			// R15: one burst word per clock
			if (bon_r) begin
				acc       = 1'b1;
				bk_nxt    = bk_r + 1'b1;
				bleft_nxt = bleft_r - 1'b1;
				if (!bfull_r && bleft_r == CW'(1)) begin
					bon_nxt = 1'b0;
					// R08: self-timed close at burst end
					if (bap_r)
						open_nxt[bbank_r] = 1'b0;
				end
			end
			case (cmd)
				// R03: bank and row chosen on activate
				CMD_ACT: begin
					open_nxt[bank] = 1'b1;
					row_nxt[bank]  = lnk.addr;
				end
				// R09: a new column command every cycle
				CMD_RD, CMD_WR: begin
					if (open_r[bank]) begin
						// R11: interrupted auto precharge still closes its bank
						if (bon_r && bap_r && bbank_r != bank)
							open_nxt[bbank_r] = 1'b0;
						acc        = 1'b1;
						acc_wr     = (cmd == CMD_WR);
						acc_bank   = bank;
						// R04: starting column
						acc_col    = lnk.addr[CW-1:0];
						bwr_nxt    = acc_wr;
						bap_nxt    = lnk.addr[AP_BIT];
						bbank_nxt  = bank;
						bstart_nxt = lnk.addr[CW-1:0];
						bk_nxt     = CW'(1);
						bleft_nxt  = CW'(len - 1'b1);
						bfull_nxt  = (mode_r[MODE_BL_LSB +: 3] == BL_PAGE);
						bon_nxt    = (len != (CW+1)'(1));
						open_nxt[bank] = !(len == (CW+1)'(1) && lnk.addr[AP_BIT]);
					end
				end
				// R07: terminate stops the burst this cycle
				CMD_BST: begin
					acc     = 1'b0;
					bon_nxt = 1'b0;
					if (bon_r && bap_r)
						open_nxt[bbank_r] = 1'b0;
				end
				// R10: precharge touches only the named bank, or every bank when address bit 10 is set
				CMD_PRE: begin
					if (lnk.addr[AP_BIT])
						open_nxt = '0;
					else
						open_nxt[bank] = 1'b0;
					if (bon_r && (lnk.addr[AP_BIT] || bank == bbank_r)) begin
						acc     = 1'b0;
						bon_nxt = 1'b0;
					end
				end
				CMD_LMR: begin
					if (!bon_r)
						mode_nxt = lnk.addr[MODE_W-1:0];
				end
				default: ;
			endcase
		end
		acc_idx = {acc_bank, row_r[acc_bank], acc_col};
	end

	// R01: every input taken at the rising edge
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			open_r   <= '0;
			row_r    <= '{default: '0};
			mode_r   <= MODE_RESET;
			bon_r    <= 1'b0;
			bwr_r    <= 1'b0;
			bap_r    <= 1'b0;
			bfull_r  <= 1'b0;
			bbank_r  <= 2'h0;
			bstart_r <= '0;
			bk_r     <= '0;
			bleft_r  <= '0;
		end else begin
			open_r   <= open_nxt;
			row_r    <= row_nxt;
			mode_r   <= mode_nxt;
			bon_r    <= bon_nxt;
			bwr_r    <= bwr_nxt;
			bap_r    <= bap_nxt;
			bfull_r  <= bfull_nxt;
			bbank_r  <= bbank_nxt;
			bstart_r <= bstart_nxt;
			bk_r     <= bk_nxt;
			bleft_r  <= bleft_nxt;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (acc && acc_wr)
			mem[acc_idx[RW+CW+1:0]] <= lnk.dq;
	end

	////////////////////////////////////////////////////////////////////////////////
	// R12: three-stage read pipe, latency picks the tap
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pv_r <= 3'h0;
			pd_r <= '{default: '0};
		end else if (lnk.cke) begin
			pv_r     <= {pv_r[1:0], acc && !acc_wr};
			pd_r[1]  <= pd_r[0];
			pd_r[2]  <= pd_r[1];
			if (acc && !acc_wr)
				pd_r[0] <= mem[acc_idx[RW+CW+1:0]];
		end
	end

	assign lsel            = (mode_r[MODE_LAT_LSB +: 2] == 2'h0) ? 2'h0 :
		mode_r[MODE_LAT_LSB +: 2] - 2'h1;
	assign lnk.mem_dq      = pd_r[lsel];
	assign lnk.mem_dq_oe_n = !pv_r[lsel];
endmodule : sdra_device

// *** verification/sdra_monitor.sv ***
`timescale 1ns/10ps
module sdra_monitor
	import sdra_pkg::*;
(
	input wire logic        sys_clk,
	input wire logic        rst,
	input wire logic        cke,
	input wire logic        cs_n,
	input wire logic        ras_n,
	input wire logic        cas_n,
	input wire logic        we_n,
	input wire logic        bank_select_low,
	input wire logic        bank_select_high,
	input wire logic [10:0] addr,
	input wire logic [31:0] ctl_dq,
	input wire logic        ctl_dq_oe_n,
	input wire logic [31:0] mem_dq,
	input wire logic        mem_dq_oe_n,
	input wire logic [31:0] dq
);
	logic [3:0] cmd;
	logic       col;

	assign cmd = {cs_n, ras_n, cas_n, we_n};
	assign col = (cmd == CMD_RD) || (cmd == CMD_WR);

	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	////////////////////////////////////////////////////////////////////////////////
	act_col_a: assert property (cmd == CMD_ACT && cke |=> col)
		else $error("activate not followed by a column command");
	col_bank_a: assert property (col |-> bank_select_low == $past(bank_select_low)
		&& bank_select_high == $past(bank_select_high))
		else $error("column command bank differs from activated bank");
	col_autopre_a: assert property (col |-> addr[AP_BIT])
		else $error("column command without auto precharge");
	wr_drive_a: assert property (cmd == CMD_WR |-> !ctl_dq_oe_n && dq == ctl_dq)
		else $error("write data not on the wire with the write command");
	rd_latency_a: assert property (cmd == CMD_RD && cke |-> ##[1:3] !mem_dq_oe_n)
		else $error("read data missing after read latency");
	one_driver_a: assert property (ctl_dq_oe_n || mem_dq_oe_n)
		else $error("both ends drive the data wire");
	ref_awake_a: assert property (cmd == CMD_REF |-> cke && mem_dq_oe_n)
		else $error("refresh issued while asleep or bursting");
	pd_quiet_a: assert property (!cke |-> mem_dq_oe_n && ctl_dq_oe_n)
		else $error("data wire driven during power-down");
	rd_word_a: assert property (!mem_dq_oe_n && ctl_dq_oe_n |-> dq == mem_dq)
		else $error("read word not on the data wire");
endmodule : sdra_monitor

// *** verification/quad_bank_sdram_access_tb.sv ***
`timescale 1ns/10ps
module quad_bank_sdram_access_tb
	import sdra_pkg::*;
	;
	localparam int REF_N = 20;
	logic        sys_clk;
	logic        rst;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hready;
	logic [31:0] hrdata;
	logic        hresp;
	logic [31:0] seed;
	logic [31:0] rd_q;
	logic [31:0] exp_q [logic [20:0]];
	logic [20:0] a;
	logic [20:0] last_a;
	int          n_fail;
	int          n_tests;
	int          n_ref;

	sdra_link sdra_link_i ();
	sdra_host #(.REF_INTERVAL(REF_N)) sdra_host_i (.sys_clk(sys_clk), .rst(rst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hready), .hrdata(hrdata), .hresp(hresp),
		.lnk(sdra_link_i.ctl));
	sdra_device sdra_device_i (.sys_clk(sys_clk), .rst(rst), .lnk(sdra_link_i.mem));
	sdra_monitor sdra_monitor_i (.sys_clk(sys_clk), .rst(rst), .cke(sdra_link_i.cke),
		.cs_n(sdra_link_i.cs_n), .ras_n(sdra_link_i.ras_n), .cas_n(sdra_link_i.cas_n),
		.we_n(sdra_link_i.we_n), .bank_select_low(sdra_link_i.bank_select_low),
		.bank_select_high(sdra_link_i.bank_select_high), .addr(sdra_link_i.addr),
		.ctl_dq(sdra_link_i.ctl_dq), .ctl_dq_oe_n(sdra_link_i.ctl_dq_oe_n),
		.mem_dq(sdra_link_i.mem_dq), .mem_dq_oe_n(sdra_link_i.mem_dq_oe_n),
		.dq(sdra_link_i.dq));

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	function automatic logic [31:0] mode_word(input logic [1:0] lat);
		return {26'h0, lat, 1'b0, 3'h0};
	endfunction : mode_word

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic wait_rdy;
		int k;
		k = 0;
		do begin
			@(posedge sys_clk);
			k++;
		end while (hready !== 1'b1 && k < 50);
		if (hready !== 1'b1) begin
			n_fail++;
			$display("[FAIL] %0t bus wait ran out", $time);
			wrap_up();
		end
	endtask : wait_rdy

	task automatic bus(input logic wr, input logic [7:0] ra, input logic [31:0] d);
		@(posedge sys_clk);
		hsel   <= 1'b1;
		haddr  <= {24'h0, ra};
		htrans <= 2'b10;
		hwrite <= wr;
		wait_rdy();
		htrans <= 2'b00;
		hwdata <= d;
		wait_rdy();
		rd_q = hrdata;
	endtask : bus

	task automatic rd_chk(input logic [7:0] ra, input logic [31:0] exp, input string what);
		bus(1'b0, ra, 32'h0);
		chk(rd_q, exp, what);
	endtask : rd_chk

	task automatic run_op(input logic [2:0] op);
		int k;
		bus(1'b1, REG_CMD, {29'h0, op});
		k = 0;
		do begin
			bus(1'b0, REG_STATUS, 32'h0);
			k++;
		end while (rd_q[ST_BUSY_BIT] !== 1'b0 && k < 200);
		if (k >= 200) begin
			n_fail++;
			$display("[FAIL] %0t operation never finished", $time);
			wrap_up();
		end
	endtask : run_op

	task automatic mem_wr(input logic [20:0] ma, input logic [31:0] d);
		bus(1'b1, REG_ADDR, {11'h0, ma});
		bus(1'b1, REG_WDATA, d);
		run_op(OP_WRITE);
		exp_q[ma] = d;
	endtask : mem_wr

	task automatic mem_rd(input logic [20:0] ma);
		bus(1'b1, REG_ADDR, {11'h0, ma});
		run_op(OP_READ);
		rd_chk(REG_RDATA, exp_q[ma], "read back");
	endtask : mem_rd

	task automatic set_lat(input logic [1:0] lat);
		bus(1'b1, REG_MODE, mode_word(lat));
		run_op(OP_MODE);
		rd_chk(REG_MODE, mode_word(lat), "mode word");
	endtask : set_lat

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) begin
		if (sdra_link_i.cke === 1'b1 && {sdra_link_i.cs_n, sdra_link_i.ras_n,
			sdra_link_i.cas_n, sdra_link_i.we_n} === CMD_REF) begin
			n_ref++;
		end
	end

	initial begin
		repeat (100000) @(posedge sys_clk);
		n_fail++;
		$display("[FAIL] %0t run ran out of time", $time);
		wrap_up();
	end

	initial begin
		rst     = 1'b1;
		hsel    = 1'b0;
		haddr   = 32'h0;
		htrans  = 2'b00;
		hwrite  = 1'b0;
		hsize   = 3'h2;
		hwdata  = 32'h0;
		seed    = 32'hfa80d4b6;
		last_a  = 21'h0;
		n_fail  = 0;
		n_tests = 0;
		n_ref   = 0;
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		rd_chk(REG_CTRL, CTRL_RESET, "refresh enable at reset");
		rd_chk(8'h1c, 32'h0, "unmapped read");
		chk({31'h0, hresp}, 32'h0, "bus response");
		chk({31'h0, sdra_link_i.cke}, 32'h1, "awake after reset");
		$display("reset checks done");
		mem_wr(21'h1fffff, 32'h5a5aa5a5);
		mem_wr(21'h000000, 32'hffffffff);
		mem_rd(21'h1fffff);
		mem_rd(21'h000000);
		$display("corner addresses done");
		for (int l = 1; l <= 3; l++) begin
			set_lat(l[1:0]);
			for (int i = 0; i < 6; i++) begin
				seed = lfsr(seed);
				a = seed[20:0];
				seed = lfsr(seed);
				mem_wr(a, seed);
				if (i > 0) begin
					mem_rd(last_a);
				end
				mem_rd(a);
				last_a = a;
			end
			$display("latency %0d done", l);
		end
		run_op(OP_PD_ENTER);
		bus(1'b0, REG_STATUS, 32'h0);
		chk({31'h0, rd_q[ST_PD_BIT]}, 32'h1, "power-down flag");
		chk({31'h0, sdra_link_i.cke}, 32'h0, "clock enable low");
		run_op(OP_PD_EXIT);
		bus(1'b0, REG_STATUS, 32'h0);
		chk({31'h0, rd_q[ST_PD_BIT]}, 32'h0, "power-down left");
		mem_rd(last_a);
		$display("power-down done");
		bus(1'b1, REG_CTRL, 32'h0);
		repeat (4) @(posedge sys_clk);
		n_ref = 0;
		repeat (3 * REF_N) @(posedge sys_clk);
		chk(32'(n_ref), 32'h0, "no refresh while disabled");
		bus(1'b1, REG_CTRL, 32'h1);
		n_ref = 0;
		repeat (3 * REF_N) @(posedge sys_clk);
		chk({31'h0, n_ref >= 2}, 32'h1, "refresh rate");
		$display("refresh done");
		wrap_up();
	end
endmodule : quad_bank_sdram_access_tb
